// file: shared/iomux_pkg.sv
// constants for the pad pull and port mapping block
// assumes: compiled before the interface and the design modules
package iomux_pkg;

    // --------------------------------------------------------------
    // sizes
    // --------------------------------------------------------------
    localparam int NPIN = 27;
    localparam int NPORT = 21;
    localparam int NSEG = 24;
    localparam int DW = 32;
    localparam int SEG_MAX = 8;

    // --------------------------------------------------------------
    // port indices, narrowest first: a lower index wins a shared pin
    // --------------------------------------------------------------
    localparam logic [4:0] SINGLE_PORT_A = 5'h00;
    localparam logic [4:0] SINGLE_PORT_B = 5'h01;
    localparam logic [4:0] SINGLE_PORT_C = 5'h02;
    localparam logic [4:0] SINGLE_PORT_D = 5'h03;
    localparam logic [4:0] SINGLE_PORT_L = 5'h04;
    localparam logic [4:0] SINGLE_PORT_M = 5'h05;
    localparam logic [4:0] SINGLE_PORT_N = 5'h06;
    localparam logic [4:0] SINGLE_PORT_O = 5'h07;
    localparam logic [4:0] SINGLE_PORT_P = 5'h08;
    localparam logic [4:0] QUAD_PORT_B = 5'h09;
    localparam logic [4:0] QUAD_PORT_C = 5'h0A;
    localparam logic [4:0] QUAD_PORT_D = 5'h0B;
    localparam logic [4:0] QUAD_PORT_E = 5'h0C;
    localparam logic [4:0] QUAD_PORT_F = 5'h0D;
    localparam logic [4:0] OCTET_PORT_A = 5'h0E;
    localparam logic [4:0] OCTET_PORT_B = 5'h0F;
    localparam logic [4:0] OCTET_PORT_C = 5'h10;
    localparam logic [4:0] OCTET_PORT_D = 5'h11;
    localparam logic [4:0] HALFWORD_PORT_A = 5'h12;
    localparam logic [4:0] HALFWORD_PORT_B = 5'h13;
    localparam logic [4:0] WORD_PORT_A = 5'h14;
    localparam logic [4:0] NO_PORT = 5'h1F;

    // --------------------------------------------------------------
    // pin map: runs of consecutive pins carrying consecutive port bits
    // --------------------------------------------------------------
    typedef struct packed {
        logic [4:0] port;
        logic [4:0] pin;
        logic [4:0] bit_idx;
        logic [3:0] count;
    } seg_type;

    localparam seg_type SEG_MAP [NSEG] = '{
        '{SINGLE_PORT_A, 5'h00, 5'h00, 4'h1},
        '{SINGLE_PORT_B, 5'h01, 5'h00, 4'h1},
        '{SINGLE_PORT_C, 5'h06, 5'h00, 4'h1},
        '{SINGLE_PORT_D, 5'h07, 5'h00, 4'h1},
        '{SINGLE_PORT_L, 5'h12, 5'h00, 4'h1},
        '{SINGLE_PORT_M, 5'h13, 5'h00, 4'h1},
        '{SINGLE_PORT_N, 5'h14, 5'h00, 4'h1},
        '{SINGLE_PORT_O, 5'h15, 5'h00, 4'h1},
        '{SINGLE_PORT_P, 5'h16, 5'h00, 4'h1},
        '{QUAD_PORT_B, 5'h02, 5'h00, 4'h4},
        '{QUAD_PORT_C, 5'h08, 5'h00, 4'h2},
        '{QUAD_PORT_D, 5'h0A, 5'h00, 4'h4},
        '{QUAD_PORT_E, 5'h0E, 5'h00, 4'h2},
        '{QUAD_PORT_F, 5'h10, 5'h00, 4'h2},
        '{OCTET_PORT_A, 5'h02, 5'h02, 4'h4},
        '{OCTET_PORT_B, 5'h08, 5'h00, 4'h6},
        '{OCTET_PORT_C, 5'h0E, 5'h00, 4'h4},
        '{OCTET_PORT_D, 5'h13, 5'h00, 4'h8},
        '{HALFWORD_PORT_A, 5'h02, 5'h02, 4'h4},
        '{HALFWORD_PORT_A, 5'h08, 5'h08, 4'h6},
        '{HALFWORD_PORT_B, 5'h0E, 5'h00, 4'h4},
        '{HALFWORD_PORT_B, 5'h13, 5'h08, 4'h8},
        '{WORD_PORT_A, 5'h02, 5'h16, 4'h4},
        '{WORD_PORT_A, 5'h08, 5'h1C, 4'h2}
    };

    // --------------------------------------------------------------
    // serial link pins and pull layout
    // --------------------------------------------------------------
    localparam logic [4:0] LINK_RX1_PIN = 5'h17;
    localparam logic [4:0] LINK_RX0_PIN = 5'h18;
    localparam logic [4:0] LINK_TX0_PIN = 5'h19;
    localparam logic [4:0] LINK_TX1_PIN = 5'h1A;
    localparam logic [NPIN-1:0] LINK_PIN_MASK = 27'h7800000;
    localparam logic [NPIN-1:0] LINK_TX_MASK = 27'h6000000;
    localparam logic [NPIN-1:0] PULL_UP_MASK = 27'h0000000;
    localparam logic [NPIN-1:0] PULL_RESET = 27'h7FFFFFF;
    localparam logic [DW-1:0] WORD_A_BONDED = 32'h33C00000;

    // --------------------------------------------------------------
    // register map (byte addresses) and reset values
    // --------------------------------------------------------------
    localparam logic [7:0] ADDR_PORT_EN = 8'h00;
    localparam logic [7:0] ADDR_PORT_DIR = 8'h04;
    localparam logic [7:0] ADDR_LINK_CTRL = 8'h08;
    localparam logic [7:0] ADDR_PULL = 8'h0C;
    localparam logic [7:0] ADDR_PIN_STATE = 8'h10;
    localparam logic [7:0] ADDR_PULL_ARMED = 8'h14;
    localparam logic [NPORT-1:0] PORT_EN_RESET = 21'h000000;
    localparam logic [NPORT-1:0] PORT_DIR_RESET = 21'h000000;

endpackage : iomux_pkg

// file: shared/iomux_cfg_if.sv
// configuration and status between the register slave and the pad mux
// assumes: iomux_pkg compiled first
`timescale 1ns/1ps
`default_nettype none
interface iomux_cfg_if;
    import iomux_pkg::*;
    logic [NPORT-1:0] port_en;
    logic [NPORT-1:0] port_dir;
    logic link_en;
    logic pull_wr;
    logic [NPIN-1:0] pull_wdata;
    logic [NPIN-1:0] pull_state;
    logic [NPIN-1:0] pull_armed;
    logic [NPIN-1:0] pin_state;
    modport regs (output port_en, port_dir, link_en, pull_wr, pull_wdata,
                  input pull_state, pull_armed, pin_state);
    modport mux (input port_en, port_dir, link_en, pull_wr, pull_wdata,
                 output pull_state, pull_armed, pin_state);
endinterface : iomux_cfg_if
`default_nettype wire

// file: logic/iomux_apb_regs.sv
// apb slave holding port enables, directions, link enable and pull control
// assumes: single clock, one wait state per access, pad mux on the cfg side
`timescale 1ns/1ps
`default_nettype none
module iomux_apb_regs
    import iomux_pkg::*;
(
    input wire logic clk,
    input wire logic nrst,
    input wire logic [7:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    iomux_cfg_if.regs cfg
);

    typedef struct packed {
        logic [NPORT-1:0] port_en;
        logic [NPORT-1:0] port_dir;
        logic link_en;
        logic pull_wr;
        logic [NPIN-1:0] pull_wdata;
        logic ready;
        logic slverr;
        logic [31:0] rdata;
    } regs_state_type;

    regs_state_type st_ff;
    regs_state_type nxt_st;
    logic [31:0] merged;

    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] wd,
                                          input logic [3:0] be);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (be[b]) begin
                r[b*8 +: 8] = wd[b*8 +: 8];
            end
        end
        return r;
    endfunction : merge

    // ------------------------------------------------------------
    // access decode: answer on the second access cycle
    // ------------------------------------------------------------
    always_comb begin
        nxt_st = st_ff;
        merged = '0;
        nxt_st.pull_wr = 1'b0;
        nxt_st.ready = 1'b0;
        if (psel && penable && !st_ff.ready) begin
            nxt_st.ready = 1'b1;
            nxt_st.slverr = 1'b0;
            nxt_st.rdata = '0;
            case (paddr)
                ADDR_PORT_EN: nxt_st.rdata = 32'(st_ff.port_en);
                ADDR_PORT_DIR: nxt_st.rdata = 32'(st_ff.port_dir);
                ADDR_LINK_CTRL: nxt_st.rdata = 32'(st_ff.link_en);
                ADDR_PULL: nxt_st.rdata = 32'(cfg.pull_state);
                ADDR_PIN_STATE: nxt_st.rdata = 32'(cfg.pin_state);
                ADDR_PULL_ARMED: nxt_st.rdata = 32'(cfg.pull_armed);
                default: nxt_st.slverr = 1'b1;
            endcase
        end
        if (psel && penable && st_ff.ready && pwrite && !st_ff.slverr) begin
            case (paddr)
                ADDR_PORT_EN: begin
                    merged = merge(32'(st_ff.port_en), pwdata, pstrb);
                    nxt_st.port_en = merged[NPORT-1:0];
                end
                ADDR_PORT_DIR: begin
                    merged = merge(32'(st_ff.port_dir), pwdata, pstrb);
                    nxt_st.port_dir = merged[NPORT-1:0];
                end
                ADDR_LINK_CTRL: begin
                    if (pstrb[0]) begin
                        nxt_st.link_en = pwdata[0];
                    end
                end
                ADDR_PULL: begin
                    merged = merge(32'(cfg.pull_state), pwdata, pstrb);
                    nxt_st.pull_wr = 1'b1;
                    nxt_st.pull_wdata = merged[NPIN-1:0];
                end
                default: nxt_st.pull_wr = 1'b0;
            endcase
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            st_ff <= '{port_en: PORT_EN_RESET, port_dir: PORT_DIR_RESET, default: '0};
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign prdata = st_ff.rdata;
    assign pready = st_ff.ready;
    assign pslverr = st_ff.slverr;
    assign cfg.port_en = st_ff.port_en;
    assign cfg.port_dir = st_ff.port_dir;
    assign cfg.link_en = st_ff.link_en;
    assign cfg.pull_wr = st_ff.pull_wr;
    assign cfg.pull_wdata = st_ff.pull_wdata;

    a_ready_one_cycle: assert property (@(posedge clk) disable iff (!nrst)
        pready |=> !pready) else $error("pready held longer than one cycle");

endmodule : iomux_apb_regs
`default_nettype wire

// file: logic/iomux_pad_top.sv
// pad mux: maps port and link signals onto the general-purpose pins
// and keeps each pin's weak pull resistor
// assumes: port data from port logic on CLK_SYS, pins asynchronous
//
// Implementation choices: the APB register port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module iomux_pad_top
    import iomux_pkg::*;
(
    input wire logic CLK_SYS,
    input wire logic NRST,
    input wire logic [7:0] PADDR,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [31:0] PWDATA,
    input wire logic [3:0] PSTRB,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    input wire logic [NPIN-1:0] PAD_IN,
    output logic [NPIN-1:0] PAD_OUT,
    output logic [NPIN-1:0] PAD_OE,
    output logic [NPIN-1:0] PAD_PULLDN_EN,
    output logic [NPIN-1:0] PAD_PULLUP_EN,
    output logic RST_PULLUP_EN,
    input wire logic [NPORT*DW-1:0] PORT_DOUT,
    output logic [NPORT*DW-1:0] PORT_DIN,
    input wire logic [1:0] LINK_TX_DATA,
    output logic [1:0] LINK_RX_DATA
);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        logic [NPIN-1:0] pad_meta;
        logic [NPIN-1:0] pad_sync;
        logic [NPIN-1:0] pad_out;
        logic [NPIN-1:0] pad_oe;
        logic [NPIN-1:0] pull;
        logic [NPIN-1:0] armed;
        logic [NPIN-1:0] used;
        logic [NPORT-1:0][DW-1:0] din;
        logic [1:0] link_rx;
        logic rst_pull;
    } mux_state_type;

    mux_state_type st_ff;
    mux_state_type nxt_st;
    logic [NPORT-1:0][DW-1:0] dout_v;
    logic [NPIN-1:0][4:0] own_port;
    logic [NPIN-1:0][4:0] own_bit;
    logic [NPIN-1:0] use_v;
    logic [NPIN-1:0] new_claim;
    logic [4:0] pin;
    logic [4:0] bi;

    iomux_cfg_if cfg ();

    iomux_apb_regs u_regs (
        .clk(CLK_SYS),
        .nrst(NRST),
        .paddr(PADDR),
        .psel(PSEL),
        .penable(PENABLE),
        .pwrite(PWRITE),
        .pwdata(PWDATA),
        .pstrb(PSTRB),
        .prdata(PRDATA),
        .pready(PREADY),
        .pslverr(PSLVERR),
        .cfg(cfg.regs)
    );

    assign dout_v = PORT_DOUT;

    // ------------------------------------------------------------
    // pin ownership, pad drive, sampling and pull control
    // ------------------------------------------------------------
    always_comb begin
        nxt_st = st_ff;
        own_port = {NPIN{NO_PORT}};
        own_bit = '0;
        use_v = '0;
        pin = '0;
        bi = '0;
        nxt_st.pad_meta = PAD_IN;
        nxt_st.pad_sync = st_ff.pad_meta;
        // lowest index among enabled ports on a pin is the narrowest
        for (int s = 0; s < NSEG; s++) begin
            for (int k = 0; k < SEG_MAX; k++) begin
                if (k < int'(SEG_MAP[s].count)) begin
                    pin = SEG_MAP[s].pin + 5'(k);
                    bi = SEG_MAP[s].bit_idx + 5'(k);
                    if (cfg.port_en[SEG_MAP[s].port]) begin
                        use_v[pin] = 1'b1;
                        if (SEG_MAP[s].port < own_port[pin]) begin
                            own_port[pin] = SEG_MAP[s].port;
                            own_bit[pin] = bi;
                        end
                    end
                end
            end
        end
        if (cfg.link_en) begin
            use_v = use_v | LINK_PIN_MASK;
            for (int p = 0; p < NPIN; p++) begin
                if (LINK_PIN_MASK[p]) begin
                    own_port[p] = NO_PORT;
                end
            end
        end
        // bits with no pin, or whose pin is taken, read as zero
        nxt_st.din = '0;
        for (int p = 0; p < NPIN; p++) begin
            nxt_st.pad_out[p] = 1'b0;
            nxt_st.pad_oe[p] = 1'b0;
            if (own_port[p] != NO_PORT) begin
                if (cfg.port_dir[own_port[p]]) begin
                    nxt_st.pad_oe[p] = 1'b1;
                    nxt_st.pad_out[p] = dout_v[own_port[p]][own_bit[p]];
                end else begin
                    nxt_st.din[own_port[p]][own_bit[p]] = st_ff.pad_sync[p];
                end
            end
        end
        nxt_st.link_rx = 2'b00;
        if (cfg.link_en) begin
            nxt_st.pad_oe[LINK_TX0_PIN] = 1'b1;
            nxt_st.pad_oe[LINK_TX1_PIN] = 1'b1;
            nxt_st.pad_out[LINK_TX0_PIN] = LINK_TX_DATA[0];
            nxt_st.pad_out[LINK_TX1_PIN] = LINK_TX_DATA[1];
            nxt_st.link_rx = {st_ff.pad_sync[LINK_RX1_PIN], st_ff.pad_sync[LINK_RX0_PIN]};
        end
        // a pin newly taken by a port or the link drops its pull
        new_claim = use_v & ~st_ff.used;
        nxt_st.used = use_v;
        nxt_st.armed = st_ff.armed | new_claim;
        if (cfg.pull_wr) begin
            nxt_st.pull = (cfg.pull_wdata & st_ff.armed) | (st_ff.pull & ~st_ff.armed);
        end
        nxt_st.pull = nxt_st.pull & ~new_claim;
        nxt_st.rst_pull = 1'b1;
    end

    always_ff @(posedge CLK_SYS or negedge NRST) begin
        if (!NRST) begin
            st_ff <= '{pull: PULL_RESET, rst_pull: 1'b1, default: '0};
        end else begin
            st_ff <= nxt_st;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign PAD_OUT = st_ff.pad_out;
    assign PAD_OE = st_ff.pad_oe;
    assign PAD_PULLDN_EN = st_ff.pull & ~PULL_UP_MASK;
    assign PAD_PULLUP_EN = st_ff.pull & PULL_UP_MASK;
    assign RST_PULLUP_EN = st_ff.rst_pull;
    assign PORT_DIN = st_ff.din;
    assign LINK_RX_DATA = st_ff.link_rx;
    assign cfg.pull_state = st_ff.pull;
    assign cfg.pull_armed = st_ff.armed;
    assign cfg.pin_state = st_ff.pad_sync;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (!NRST);

    a_pull_fixed_dir: assert property (
        (PAD_PULLDN_EN | PAD_PULLUP_EN) == st_ff.pull && (PAD_PULLDN_EN & PAD_PULLUP_EN) == '0)
        else $error("pull enable does not match its fixed direction");

    a_pull_held_on: assert property (
        (st_ff.pull | st_ff.armed) == {NPIN{1'b1}})
        else $error("pull dropped before any claim");

    a_claim_pull_off: assert property (
        new_claim != '0 |=> (st_ff.pull & $past(new_claim)) == '0 && (st_ff.armed & $past(new_claim)) == $past(new_claim))
        else $error("claimed pin kept its pull");

    a_sw_pull_write: assert property (
        cfg.pull_wr |=> ((st_ff.pull ^ $past(cfg.pull_wdata)) & $past(st_ff.armed) & ~$past(new_claim)) == '0)
        else $error("software pull write not applied");

    a_input_no_drive: assert property (
        cfg.port_en[SINGLE_PORT_A] && !cfg.port_dir[SINGLE_PORT_A] |=> !PAD_OE[0] ##1 !PAD_OE[0] || $past(cfg.port_dir[SINGLE_PORT_A], 1))
        else $error("input port pin driven");

    a_word_unbonded: assert property (
        (PORT_DIN[WORD_PORT_A*DW +: DW] & ~WORD_A_BONDED) == '0)
        else $error("unbonded word port bit not zero");

    a_reset_pullup: assert property (
        $rose(NRST) |-> RST_PULLUP_EN ##1 RST_PULLUP_EN)
        else $error("reset pin pull-up off");

    a_link_owns_pins: assert property (
        cfg.link_en |=> (PAD_OE & LINK_PIN_MASK) == LINK_TX_MASK && PAD_OUT[LINK_TX0_PIN] == $past(LINK_TX_DATA[0]))
        else $error("link pins not owned by the link");

    a_narrow_wins: assert property (
        cfg.port_en[QUAD_PORT_B] && cfg.port_dir[QUAD_PORT_B]
        |=> PAD_OE[5:2] == 4'hF && PAD_OUT[5:2] == $past(dout_v[QUAD_PORT_B][3:0]))
        else $error("narrow port lost its pins");

    a_wide_keeps_pin: assert property (
        cfg.port_en[HALFWORD_PORT_A] && cfg.port_dir[HALFWORD_PORT_A] && cfg.port_en[QUAD_PORT_B]
        && !cfg.port_en[QUAD_PORT_C] && !cfg.port_en[OCTET_PORT_B]
        |=> PAD_OE[8] && PAD_OUT[8] == $past(dout_v[HALFWORD_PORT_A][8]))
        else $error("unshared wide port pin lost");

    a_map_din: assert property (
        cfg.port_en[OCTET_PORT_B] && !cfg.port_dir[OCTET_PORT_B] && !cfg.port_en[QUAD_PORT_D]
        |=> PORT_DIN[OCTET_PORT_B*DW + 2] == $past(st_ff.pad_sync[10]))
        else $error("octet port bit 2 not taken from its pin");

endmodule : iomux_pad_top
`default_nettype wire

// file: bench/iomux_pin_model.sv
// outside circuitry on the general-purpose pins
// assumes: it drives every pin that the block leaves released
`timescale 1ns/1ps
`default_nettype none
module iomux_pin_model (
    input wire logic [26:0] pad_out,
    input wire logic [26:0] pad_oe,
    input wire logic [26:0] ext_val,
    output logic [26:0] pad_in
);
    // a pin driven by the block shows its value, others the outside level
    assign pad_in = (pad_oe & pad_out) | (~pad_oe & ext_val);
endmodule : iomux_pin_model
`default_nettype wire

// file: bench/io_pad_pull_and_port_mapping_tb.sv
// self-checking bench for the pad pull and port mapping block
// assumes: iomux_pkg, the cfg interface and the design are compiled first
`timescale 1ns/1ps
`default_nettype none
module io_pad_pull_and_port_mapping_tb
    import iomux_pkg::*;
;
    logic clk_sys = 1'b0;
    logic nrst = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready, pslverr, rst_pu;
    logic [26:0] pad_in, pad_out, pad_oe, pull_dn, pull_up;
    logic [26:0] ext_val = 27'h0;
    logic [NPORT*DW-1:0] dout = '0;
    logic [NPORT*DW-1:0] din;
    logic [1:0] tx = 2'h0;
    logic [1:0] rx;
    logic [20:0] m_en = 21'h0;
    logic [20:0] m_dir = 21'h0;
    logic m_link = 1'b0;
    logic [26:0] m_pull = 27'h7FFFFFF;
    logic [26:0] m_armed = 27'h0;
    logic [26:0] m_clm = 27'h0;
    logic [26:0] m_lvl = 27'h0;
    int err_total = 0;
    int comparisons = 0;
    int seed = 32'h049F;
    int it, k, p;
    // port, first pin, first bit, pin count
    int tbl [24] = '{32'h00000001, 32'h01010001, 32'h02060001, 32'h03070001,
        32'h04120001, 32'h05130001, 32'h06140001, 32'h07150001, 32'h08160001,
        32'h09020004, 32'h0A080002, 32'h0B0A0004, 32'h0C0E0002, 32'h0D100002,
        32'h0E020204, 32'h0F080006, 32'h100E0004, 32'h11130008, 32'h12020204,
        32'h12080806, 32'h130E0004, 32'h13130808, 32'h14021604, 32'h14081C02};

    always #2.5 clk_sys = ~clk_sys;

    iomux_pad_top iomux_pad_top_i (
        .CLK_SYS(clk_sys),
        .NRST(nrst),
        .PADDR(paddr),
        .PSEL(psel),
        .PENABLE(penable),
        .PWRITE(pwrite),
        .PWDATA(pwdata),
        .PSTRB(4'hF),
        .PRDATA(prdata),
        .PREADY(pready),
        .PSLVERR(pslverr),
        .PAD_IN(pad_in),
        .PAD_OUT(pad_out),
        .PAD_OE(pad_oe),
        .PAD_PULLDN_EN(pull_dn),
        .PAD_PULLUP_EN(pull_up),
        .RST_PULLUP_EN(rst_pu),
        .PORT_DOUT(dout),
        .PORT_DIN(din),
        .LINK_TX_DATA(tx),
        .LINK_RX_DATA(rx)
    );

    iomux_pin_model iomux_pin_model_i (
        .pad_out(pad_out),
        .pad_oe(pad_oe),
        .ext_val(ext_val),
        .pad_in(pad_in)
    );

    // ----------------------------------------------------------
    // tasks
    // ----------------------------------------------------------
    task automatic final_report;
        if (err_total == 0 && comparisons > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : final_report

    task automatic chk(input logic [NPORT*DW-1:0] seen, input logic [NPORT*DW-1:0] exp);
        comparisons++;
        if (seen !== exp) begin
            err_total++;
            $display("MISMATCH %0t %0h %0h", $time, seen, exp);
        end
    endtask : chk

    // called just after a rising edge; returns one idle edge after release
    task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d,
                       output logic [31:0] rd, output logic err);
        psel <= 1'b1;
        paddr <= a;
        pwrite <= w;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        do begin
            @(posedge clk_sys);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk_sys);
    endtask : apb

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] rd;
        logic err;
        apb(a, 1'b1, d, rd, err);
        chk(err, a > 8'h14);
        case (a)
            8'h00: m_en = d[20:0];
            8'h04: m_dir = d[20:0];
            8'h08: m_link = d[0];
            8'h0C: m_pull = (m_pull & ~m_armed) | (d[26:0] & m_armed);
            default: ;
        endcase
    endtask : wr

    task automatic rdc(input logic [7:0] a);
        logic [31:0] rd, exp;
        logic err;
        apb(a, 1'b0, 32'h0, rd, err);
        case (a)
            8'h00: exp = 32'(m_en);
            8'h04: exp = 32'(m_dir);
            8'h08: exp = 32'(m_link);
            8'h0C: exp = 32'(m_pull);
            8'h10: exp = 32'(m_lvl);
            8'h14: exp = 32'(m_armed);
            default: exp = 32'h0;
        endcase
        chk({err, rd}, {a > 8'h14, exp});
    endtask : rdc

    // model of pin ownership and pulls, then compare every pin output
    task automatic check_all;
        int own [27];
        int bt [27];
        int e, x;
        logic [26:0] oe, out, clm;
        logic [NPORT*DW-1:0] dn;
        repeat (6) @(posedge clk_sys);
        oe = 27'h0;
        out = 27'h0;
        clm = 27'h0;
        dn = '0;
        foreach (own[i]) own[i] = 99;
        foreach (tbl[i]) begin
            e = tbl[i];
            for (x = 0; x < e[7:0]; x++) begin
                if (m_en[e[28:24]] && e[28:24] < own[e[20:16] + x]) begin
                    own[e[20:16] + x] = e[28:24];
                    bt[e[20:16] + x] = e[12:8] + x;
                end
            end
        end
        for (x = 23; x < 27; x++) begin
            if (m_link) own[x] = 98;
        end
        for (x = 0; x < 27; x++) begin
            clm[x] = own[x] < 99;
            if (own[x] < 98) begin
                e = own[x] * 32 + bt[x];
                if (m_dir[own[x]]) begin
                    oe[x] = 1'b1;
                    out[x] = dout[e];
                end else begin
                    dn[e] = ext_val[x];
                end
            end
        end
        if (m_link) begin
            oe[26:25] = 2'h3;
            out[26:25] = tx;
        end
        m_armed |= clm & ~m_clm;
        m_pull &= ~(clm & ~m_clm);
        m_clm = clm;
        m_lvl = (oe & out) | (~oe & ext_val);
        chk(pad_oe, oe);
        chk(pad_out, out);
        chk(din, dn);
        chk(pull_dn, m_pull);
        chk({rst_pu, pull_up}, {1'b1, 27'h0});
        chk(rx, m_link ? {ext_val[23], ext_val[24]} : 2'h0);
    endtask : check_all

    // ----------------------------------------------------------
    // sequence
    // ----------------------------------------------------------
    initial begin
        repeat (4) @(posedge clk_sys);
        nrst <= 1'b1;
        check_all;
        rdc(8'h0C);
        rdc(8'h18);
        wr(8'h0C, 32'h0);
        wr(8'h14, 32'hFFFFFFFF);
        wr(8'h1C, 32'h1);
        check_all;
        rdc(8'h14);
        for (it = 0; it < 40; it++) begin
            for (p = 0; p < NPORT; p++) dout[p*32+:32] <= $random(seed);
            ext_val <= 27'($random(seed));
            tx <= 2'($random(seed));
            for (k = 0; k < 4; k++) begin
                wr(8'(k * 4), $random(seed));
                check_all;
            end
            rdc(8'(it % 7 * 4));
        end
        // reset in mid-run: pulls back on, claims forgotten
        nrst <= 1'b0;
        repeat (2) @(posedge clk_sys);
        chk({pull_dn, pad_oe, rst_pu}, {27'h7FFFFFF, 27'h0, 1'b1});
        nrst <= 1'b1;
        m_en = 21'h0;
        m_dir = 21'h0;
        m_link = 1'b0;
        m_pull = 27'h7FFFFFF;
        m_armed = 27'h0;
        m_clm = 27'h0;
        check_all;
        rdc(8'h14);
        rdc(8'h00);
        final_report;
    end

    initial begin
        #100000;
        err_total++;
        final_report;
    end
endmodule : io_pad_pull_and_port_mapping_tb
`default_nettype wire
